/* File: modbus_rtu_pkg.sv */
// shared constants, types and crc helper for the modbus rtu link ends
package modbus_rtu_pkg;

	localparam logic [7:0]  FC_READ     = 8'h03;
	localparam logic [7:0]  FC_WRITE    = 8'h06;
	localparam logic [7:0]  FC_EXC_BIT  = 8'h80;
	localparam logic [7:0]  EXC_FUNC    = 8'h01;
	localparam logic [7:0]  EXC_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_VALUE   = 8'h03;
	localparam logic [7:0]  DEFAULT_ID  = 8'h01;
	localparam logic [7:0]  MAX_ID      = 8'hF7;
	localparam logic [15:0] ID_REG      = 16'h0096;
	localparam logic [15:0] MAX_COUNT   = 16'h007D;
	localparam logic [3:0]  REQ_BYTES   = 4'h8;
	localparam logic [3:0]  LAST_REQ    = 4'h7;
	localparam logic [8:0]  READ_EXTRA  = 9'h005;
	localparam logic [8:0]  WRITE_BYTES = 9'h008;
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;

	localparam longint unsigned CLK_HZ          = 250_000_000;
	localparam longint unsigned RESP_MAX_S      = 10;
	localparam longint unsigned MASTER_WAIT_MS  = 10_000;
	// longest time rounds down, least time rounds up
	localparam longint unsigned RESP_MAX_CYC    = RESP_MAX_S * CLK_HZ;
	localparam longint unsigned MASTER_WAIT_CYC = (MASTER_WAIT_MS * CLK_HZ + 999) / 1000;

	localparam logic [1:0] PART_HDR    = 2'h0;
	localparam logic [1:0] PART_DATA   = 2'h1;
	localparam logic [1:0] PART_CRC_LO = 2'h2;
	localparam logic [1:0] PART_CRC_HI = 2'h3;

	typedef enum logic [3:0] {
		S_RX    = 4'h1,
		S_EXEC  = 4'h2,
		S_LATCH = 4'h4,
		S_TX    = 4'h8
	} slave_state_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h1,
		M_TX   = 3'h2,
		M_RX   = 3'h4
	} master_state_t;

	typedef enum logic [2:0] {
		ST_OK      = 3'h0,
		ST_EXC     = 3'h1,
		ST_TIMEOUT = 3'h2,
		ST_CRC     = 3'h3,
		ST_BADCMD  = 3'h4,
		ST_FORMAT  = 3'h5
	} rsp_status_t;

	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

/* File: modbus_rtu_link_if.sv */
// byte-level rtu link between master and slave ends
`timescale 1ns/1ns
interface modbus_rtu_link_if;
	logic       m2s_valid;
	logic [7:0] m2s_data;
	logic       m2s_last;
	logic       m2s_err;
	logic       s2m_valid;
	logic       s2m_ready;
	logic [7:0] s2m_data;
	logic       s2m_last;

	modport slave_port (
		input  m2s_valid, m2s_data, m2s_last, m2s_err, s2m_ready,
		output s2m_valid, s2m_data, s2m_last
	);
	modport master_port (
		output m2s_valid, m2s_data, m2s_last, m2s_err, s2m_ready,
		input  s2m_valid, s2m_data, s2m_last
	);
endinterface

/* File: modbus_rtu_slave_port.sv */
// modbus rtu slave end: request check, register access, reply build
// Function
// R1 - slave on rtu link, answers master only
// R2 - identifier 1 after reset
// R3 - write to register 150 changes identifier
// R4 - reply finished within 10 seconds
// R5 - master waits at least 10000 ms
// R6 - read request is eight bytes, code 03
// R7 - start register sent high byte first
// R8 - count high byte 0, low 1 to 125
// R9 - read reply: id, 03, count, words, crc
// R10 - byte count equals data bytes following
// R11 - read reply totals 2N+5 bytes
// R12 - write request is eight bytes, code 06
// R13 - write acknowledged by echo with new crc
// R14 - bad register gives five-byte exception reply
// R15 - range past last register gives code 02
// R16 - framing or crc error: silent discard
// R17 - high word read latches low word
// R18 - crc-16 trails every frame, low first
// R19 - other identifiers are ignored silently
`timescale 1ns/1ns
module modbus_rtu_slave_port import modbus_rtu_pkg::*; #(
	parameter logic [15:0] NUM_REGS   = 16'h0100,
	parameter logic [15:0] WIDE_BASE  = 16'h0000,
	parameter logic [15:0] WIDE_END   = 16'h0002,
	parameter logic [31:0] RESP_LIMIT = 32'(RESP_MAX_CYC)
) (
	input  wire logic              sys_clk_in,   // system clock
	input  wire logic              sys_rst_in,   // sync reset, high
	modbus_rtu_link_if.slave_port  link,         // rtu byte link
	output logic [15:0]            rd_addr_out,  // register read address
	input  wire logic [15:0]       rd_data_in,   // register read data, same cycle
	output logic                   wr_valid_out, // register write pulse
	output logic [15:0]            wr_addr_out,  // register write address
	output logic [31:0]            wr_data_out,  // write data, low 16 unless wide
	output logic                   wr_wide_out,  // 32-bit pair write
	output logic [7:0]             slave_id_out  // current identifier
);

	typedef struct packed {
		slave_state_t     st;
		logic [7:0][7:0]  rx;
		logic [3:0]       rx_cnt;
		logic [15:0]      rx_crc;
		logic             rx_bad;
		logic [7:0]       id;
		logic [5:0][7:0]  hdr;
		logic [2:0]       hdr_len;
		logic [2:0]       idx;
		logic [1:0]       part;
		logic             has_data;
		logic [15:0]      tx_crc;
		logic [15:0]      cur;
		logic [7:0]       left;
		logic             lo_half;
		logic [15:0]      word;
		logic [15:0]      latch_word;
		logic [15:0]      latch_addr;
		logic             latch_ok;
		logic [15:0]      hold_word;
		logic [15:0]      hold_addr;
		logic             hold_ok;
		logic             wr_valid;
		logic [15:0]      wr_addr;
		logic [31:0]      wr_data;
		logic             wr_wide;
		logic [31:0]      timer;
	} slave_regs_t;

	slave_regs_t r;
	slave_regs_t next_r;

	logic [7:0]  fc;
	logic [15:0] a;
	logic [15:0] v;
	logic [16:0] read_end;
	logic [15:0] src_word;
	logic [7:0]  tx_byte;
	logic        fire;

	function automatic logic in_wide(input logic [15:0] x);
		return (x >= WIDE_BASE) && (x < WIDE_END);
	endfunction

	function automatic logic wide_hi(input logic [15:0] x);
		return in_wide(x) && (x[0] == WIDE_BASE[0]);
	endfunction

	assign fc       = r.rx[1];
	assign a        = {r.rx[2], r.rx[3]};                              // [R7]
	assign v        = {r.rx[4], r.rx[5]};
	assign read_end = {1'b0, a} + {1'b0, v};

	// low word of a pair comes from the copy taken just before its high word went out
	always_comb begin
		if (r.cur == ID_REG) begin
			src_word = {8'h00, r.id};
		end else if (in_wide(r.cur) && !wide_hi(r.cur) && r.latch_ok && r.latch_addr == r.cur) begin
			src_word = r.latch_word;                                   // [R17]
		end else begin
			src_word = rd_data_in;
		end
	end

	always_comb begin
		unique case (r.part)
			PART_HDR:    tx_byte = r.hdr[r.idx];
			PART_DATA:   tx_byte = r.lo_half ? r.word[7:0] : src_word[15:8]; // [R9]
			PART_CRC_LO: tx_byte = r.tx_crc[7:0];                          // [R18]
			PART_CRC_HI: tx_byte = r.tx_crc[15:8];
		endcase
	end

	assign fire = (r.st == S_TX) && link.s2m_ready;

	always_comb begin
		next_r = r;
		next_r.wr_valid = 1'b0;
		unique case (r.st)
			S_RX: begin
				// one request at a time; bytes during a reply are ignored [R1]
				if (link.m2s_valid) begin
					if (r.rx_cnt < REQ_BYTES) begin
						next_r.rx[r.rx_cnt[2:0]] = link.m2s_data;
						next_r.rx_cnt = r.rx_cnt + 4'h1;
					end else begin
						next_r.rx_bad = 1'b1;
					end
					next_r.rx_crc = crc16_step(r.rx_crc, link.m2s_data);
					if (link.m2s_err) begin
						next_r.rx_bad = 1'b1;                                  // [R16]
					end
					if (link.m2s_last) begin
						next_r.st = S_EXEC;
					end
				end
			end
			S_EXEC: begin
				next_r.st = S_RX;
				next_r.rx_cnt = 4'h0;
				next_r.rx_bad = 1'b0;
				next_r.rx_crc = CRC_INIT;
				// residue of zero means the trailing crc matched [R18]
				if (!r.rx_bad && r.rx_cnt == REQ_BYTES && r.rx_crc == 16'h0000 // [R16] [R6] [R12]
					&& r.rx[0] == r.id) begin                              // [R19] [R2]
					next_r.st = S_TX;
					next_r.idx = 3'h0;
					next_r.part = PART_HDR;
					next_r.tx_crc = CRC_INIT;
					next_r.timer = 32'h0;
					next_r.has_data = 1'b0;
					next_r.hdr_len = 3'h3;
					next_r.hdr[0] = r.rx[0];
					next_r.hdr[1] = fc | FC_EXC_BIT;                         // [R14]
					next_r.hdr[2] = EXC_FUNC;
					if (fc == FC_READ) begin
						if (v == 16'h0000 || v > MAX_COUNT) begin
							next_r.hdr[2] = EXC_VALUE;                         // [R8]
						end else if (read_end > {1'b0, NUM_REGS}) begin
							next_r.hdr[2] = EXC_ADDR;                          // [R15]
						end else begin
							next_r.hdr[1] = FC_READ;                           // [R9]
							next_r.hdr[2] = {v[6:0], 1'b0};                    // [R10]
							next_r.has_data = 1'b1;
							next_r.cur = a;
							next_r.left = v[7:0];
							next_r.lo_half = 1'b0;
						end
					end else if (fc == FC_WRITE) begin
						if (a >= NUM_REGS) begin
							next_r.hdr[2] = EXC_ADDR;                          // [R14]
						end else if (a == ID_REG && (v == 16'h0000 || v > {8'h00, MAX_ID})) begin
							next_r.hdr[2] = EXC_VALUE;
						end else begin
							next_r.hdr = r.rx[5:0];                            // [R13]
							next_r.hdr_len = 3'h6;
							if (a == ID_REG) begin
								next_r.id = v[7:0];                              // [R3]
							end else if (wide_hi(a)) begin
								// high half waits for its partner [R17]
								next_r.hold_word = v;
								next_r.hold_addr = a;
								next_r.hold_ok = 1'b1;
							end else if (in_wide(a) && r.hold_ok && r.hold_addr + 16'h0001 == a) begin
								next_r.wr_valid = 1'b1;                          // [R17]
								next_r.wr_addr = r.hold_addr;
								next_r.wr_data = {r.hold_word, v};
								next_r.wr_wide = 1'b1;
								next_r.hold_ok = 1'b0;
							end else begin
								next_r.wr_valid = 1'b1;
								next_r.wr_addr = a;
								next_r.wr_data = {16'h0000, v};
								next_r.wr_wide = 1'b0;
							end
						end
					end
				end
			end
			S_LATCH: begin
				// take the low word now so later reads see one snapshot [R17]
				next_r.latch_word = rd_data_in;
				next_r.latch_addr = r.cur + 16'h0001;
				next_r.latch_ok = 1'b1;
				next_r.st = S_TX;
				next_r.timer = r.timer + 32'h1;
			end
			S_TX: begin
				next_r.timer = r.timer + 32'h1;
				if (fire) begin
					if (r.part == PART_HDR || r.part == PART_DATA) begin
						next_r.tx_crc = crc16_step(r.tx_crc, tx_byte);          // [R18]
					end
					unique case (r.part)
						PART_HDR: begin
							if (r.idx == r.hdr_len - 3'h1) begin
								if (r.has_data) begin
									next_r.part = PART_DATA;
									if (wide_hi(r.cur)) begin
										next_r.st = S_LATCH;
									end
								end else begin
									next_r.part = PART_CRC_LO;
								end
							end else begin
								next_r.idx = r.idx + 3'h1;
							end
						end
						PART_DATA: begin
							if (!r.lo_half) begin
								next_r.word = src_word;
								next_r.lo_half = 1'b1;
							end else begin
								// two bytes per register, so 2N+5 in all [R11]
								next_r.lo_half = 1'b0;
								next_r.cur = r.cur + 16'h0001;
								next_r.left = r.left - 8'h01;
								if (r.left == 8'h01) begin
									next_r.part = PART_CRC_LO;
								end else if (wide_hi(r.cur + 16'h0001)) begin
									next_r.st = S_LATCH;
								end
							end
						end
						PART_CRC_LO: next_r.part = PART_CRC_HI;
						PART_CRC_HI: next_r.st = S_RX;
					endcase
				end
			end
		endcase
		// a reply stalled past its deadline is abandoned [R4]
		if ((r.st == S_TX || r.st == S_LATCH) && r.timer >= RESP_LIMIT - 32'h1) begin
			next_r.st = S_RX;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			r <= '0;
			r.st <= S_RX;
			r.id <= DEFAULT_ID;                                            // [R2]
			r.rx_crc <= CRC_INIT;
		end else begin
			r <= next_r;
		end
	end

	assign link.s2m_valid = (r.st == S_TX);
	assign link.s2m_data  = tx_byte;
	assign link.s2m_last  = (r.st == S_TX) && (r.part == PART_CRC_HI);
	assign rd_addr_out    = (r.st == S_LATCH) ? r.cur + 16'h0001 : r.cur;
	assign wr_valid_out   = r.wr_valid;
	assign wr_addr_out    = r.wr_addr;
	assign wr_data_out    = r.wr_data;
	assign wr_wide_out    = r.wr_wide;
	assign slave_id_out   = r.id;

endmodule

/* File: modbus_rtu_master_port.sv */
// modbus rtu master end: builds requests, checks replies, times out
`timescale 1ns/1ns
module modbus_rtu_master_port import modbus_rtu_pkg::*; #(
	parameter logic [31:0] WAIT_LIMIT = 32'(MASTER_WAIT_CYC)
) (
	input  wire logic              sys_clk_in,      // system clock
	input  wire logic              sys_rst_in,      // sync reset, high
	modbus_rtu_link_if.master_port link,            // rtu byte link
	input  wire logic              cmd_valid_in,    // command request
	output logic                   cmd_ready_out,   // idle, command taken
	input  wire logic              cmd_write_in,    // 1 write single, 0 read
	input  wire logic [7:0]        cmd_id_in,       // target identifier
	input  wire logic [15:0]       cmd_addr_in,     // register number
	input  wire logic [15:0]       cmd_value_in,    // write data or read count
	input  wire logic              cmd_spoil_crc_in,// send a wrong crc
	input  wire logic              cmd_bad_char_in, // flag a framing error
	output logic                   rsp_valid_out,   // reply, timeout or rejected-command pulse
	output rsp_status_t            rsp_status_out,  // outcome
	output logic [7:0]             rsp_code_out,    // exception code
	output logic                   word_valid_out,  // read word pulse
	output logic [15:0]            word_out         // read word
);

	typedef struct packed {
		master_state_t    st;
		logic [7:0][7:0]  tx;
		logic [3:0]       idx;
		logic             bad_char;
		logic [7:0]       fc;
		logic [8:0]       rx_cnt;
		logic [15:0]      rx_crc;
		logic [7:0]       rx_fc;
		logic [7:0]       rx_b2;
		logic [7:0]       hi;
		logic             word_valid;
		logic [15:0]      word;
		logic             rsp_valid;
		rsp_status_t      status;
		logic [7:0]       code;
		logic [31:0]      timer;
	} master_regs_t;

	master_regs_t r;
	master_regs_t next_r;
	logic [5:0][7:0] req;
	logic [15:0]     req_crc;
	logic [8:0]      cnt_now;

	always_comb begin
		req[0] = cmd_id_in;
		req[1] = cmd_write_in ? FC_WRITE : FC_READ;
		req[2] = cmd_addr_in[15:8];                                        // [R7]
		req[3] = cmd_addr_in[7:0];
		req[4] = cmd_write_in ? cmd_value_in[15:8] : 8'h00;               // [R8]
		req[5] = cmd_value_in[7:0];
		req_crc = CRC_INIT;
		for (int i = 0; i < 6; i++) begin
			req_crc = crc16_step(req_crc, req[i]);                           // [R18]
		end
		if (cmd_spoil_crc_in) begin
			req_crc = ~req_crc;
		end
	end

	assign cnt_now = r.rx_cnt + 9'h001;

	always_comb begin
		next_r = r;
		next_r.rsp_valid = 1'b0;
		next_r.word_valid = 1'b0;
		unique case (r.st)
			M_IDLE: begin
				if (cmd_valid_in) begin
					if (!cmd_write_in && (cmd_value_in == 16'h0000 || cmd_value_in > MAX_COUNT)) begin
						next_r.rsp_valid = 1'b1;                                  // [R8]
						next_r.status = ST_BADCMD;
					end else begin
						next_r.st = M_TX;                                         // [R6] [R12]
						next_r.tx = {req_crc[15:8], req_crc[7:0], req};
						next_r.fc = req[1];
						next_r.bad_char = cmd_bad_char_in;
						next_r.idx = 4'h0;
						next_r.timer = 32'h0;
					end
				end
			end
			M_TX: begin
				next_r.timer = r.timer + 32'h1;
				next_r.idx = r.idx + 4'h1;
				if (r.idx == LAST_REQ) begin
					next_r.st = M_RX;
					next_r.rx_cnt = 9'h000;
					next_r.rx_crc = CRC_INIT;
				end
			end
			M_RX: begin
				next_r.timer = r.timer + 32'h1;
				if (link.s2m_valid) begin
					next_r.rx_cnt = cnt_now;
					next_r.rx_crc = crc16_step(r.rx_crc, link.s2m_data);
					if (r.rx_cnt == 9'h001) next_r.rx_fc = link.s2m_data;
					if (r.rx_cnt == 9'h002) next_r.rx_b2 = link.s2m_data;
					// bytes 3 .. 2+count are register data, high byte first
					if (r.fc == FC_READ && r.rx_fc == FC_READ && r.rx_cnt >= 9'h003
						&& r.rx_cnt < {1'b0, r.rx_b2} + 9'h003) begin
						if (r.rx_cnt[0]) begin
							next_r.hi = link.s2m_data;
						end else begin
							next_r.word_valid = 1'b1;
							next_r.word = {r.hi, link.s2m_data};
						end
					end
					if (link.s2m_last) begin
						next_r.st = M_IDLE;
						next_r.rsp_valid = 1'b1;
						next_r.code = r.rx_b2;
						if (crc16_step(r.rx_crc, link.s2m_data) != 16'h0000) begin
							next_r.status = ST_CRC;
						end else if (r.rx_fc == (r.fc | FC_EXC_BIT) && cnt_now == READ_EXTRA) begin
							next_r.status = ST_EXC;
						end else if (r.rx_fc == FC_READ && r.fc == FC_READ
							&& cnt_now == {r.rx_b2, 1'b0} / 9'h002 + READ_EXTRA) begin
							next_r.status = ST_OK;                                 // [R11]
						end else if (r.rx_fc == FC_WRITE && r.fc == FC_WRITE && cnt_now == WRITE_BYTES) begin
							next_r.status = ST_OK;
						end else begin
							next_r.status = ST_FORMAT;
						end
					end
				end
			end
		endcase
		// give up only after the full wait has passed [R5]
		if (r.st != M_IDLE && r.timer >= WAIT_LIMIT - 32'h1) begin
			next_r.st = M_IDLE;
			next_r.rsp_valid = 1'b1;
			next_r.status = ST_TIMEOUT;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			r <= '0;
			r.st <= M_IDLE;
			r.rx_crc <= CRC_INIT;
		end else begin
			r <= next_r;
		end
	end

	assign link.m2s_valid = (r.st == M_TX);
	assign link.m2s_data  = r.tx[r.idx[2:0]];
	assign link.m2s_last  = (r.st == M_TX) && (r.idx == LAST_REQ);
	assign link.m2s_err   = (r.st == M_TX) && r.bad_char && (r.idx == LAST_REQ);
	assign link.s2m_ready = (r.st == M_RX);
	assign cmd_ready_out  = (r.st == M_IDLE);
	assign rsp_valid_out  = r.rsp_valid;
	assign rsp_status_out = r.status;
	assign rsp_code_out   = r.code;
	assign word_valid_out = r.word_valid;
	assign word_out       = r.word;

endmodule

/* File: modbus_rtu_slave_port_assertions.sv */
// concurrent checks on the rtu byte link between the two ends
`timescale 1ns/1ns
module modbus_rtu_slave_port_assertions (
	input wire logic       sys_clk_in, // system clock
	input wire logic       sys_rst_in, // sync reset, high
	input wire logic       m2s_valid,  // request byte present
	input wire logic [7:0] m2s_data,   // request byte
	input wire logic       m2s_last,   // last request byte
	input wire logic       m2s_err,    // framing error flag
	input wire logic       s2m_valid,  // reply byte present
	input wire logic       s2m_ready,  // master accepts
	input wire logic [7:0] s2m_data,   // reply byte
	input wire logic       s2m_last    // last reply byte
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	logic [2:0] mcnt;
	logic [7:0] req [8];
	logic [8:0] scnt;
	logic [7:0] rfc;
	logic [7:0] rbc;
	logic       busy;
	logic       hs;
	logic       req_ok;

	assign hs = s2m_valid && s2m_ready;
	assign req_ok = m2s_valid && m2s_last && !m2s_err;

	// byte positions of the frames in flight
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mcnt <= 3'h0;
			scnt <= 9'h000;
			busy <= 1'b0;
			rfc  <= 8'h00;
			rbc  <= 8'h00;
		end else begin
			if (m2s_valid) begin
				req[mcnt] <= m2s_data;
				mcnt      <= m2s_last ? 3'h0 : mcnt + 3'h1;
			end
			if (hs) begin
				scnt <= s2m_last ? 9'h000 : scnt + 9'h001;
				busy <= !s2m_last;
				if (scnt == 9'h001) rfc <= s2m_data;
				if (scnt == 9'h002) rbc <= s2m_data;
			end
		end
	end

	sequence req_end;
		m2s_valid && m2s_last && !m2s_err;
	endsequence
	sequence reply_first;
		s2m_valid && !busy;
	endsequence
	sequence reply_done;
		hs && s2m_last;
	endsequence

	AST_NO_EARLY_REPLY: assert property (req_end |=> !s2m_valid)
		else $error("reply began on the cycle after the request");
	AST_REPLY_CAUSE: assert property (reply_first |-> $past(req_ok, 2))
		else $error("reply without a clean request two cycles before");
	AST_ERR_SILENT: assert property (m2s_valid && m2s_err |=> !s2m_valid [*4])
		else $error("reply to a request with a framing error");
	AST_HALF_DUPLEX: assert property (m2s_valid |-> !s2m_valid)
		else $error("slave talked while the master was sending");
	AST_REQ_LEN: assert property (m2s_valid && m2s_last |-> mcnt == 3'h7)
		else $error("request frame is not eight bytes");
	AST_REPLY_ID: assert property (hs && scnt == 9'h000 |-> s2m_data == req[0])
		else $error("reply identifier differs from request");
	AST_REPLY_FC: assert property (hs && scnt == 9'h001 |-> s2m_data == req[1] || s2m_data == (req[1] | 8'h80))
		else $error("reply function code does not match request");
	AST_READ_CNT: assert property (hs && scnt == 9'h002 && rfc == 8'h03 |-> s2m_data == {req[5][6:0], 1'b0})
		else $error("byte count is not twice the register count");
	AST_READ_LEN: assert property (reply_done and rfc == 8'h03 |-> scnt == {1'b0, rbc} + 9'h004)
		else $error("read reply length is not byte count plus five");
	AST_ECHO_LEN: assert property (reply_done and rfc == 8'h06 |-> scnt == 9'h007)
		else $error("write echo is not eight bytes");
	AST_EXC_LEN: assert property (reply_done and rfc[7] |-> scnt == 9'h004)
		else $error("exception reply is not five bytes");
	AST_ECHO_DATA: assert property (hs && rfc == 8'h06 && scnt >= 9'h002 && scnt <= 9'h005 |-> s2m_data == req[scnt[2:0]])
		else $error("write echo field differs from request");
	AST_REPLY_BOUND: assert property (reply_first |-> ##[0:300] reply_done)
		else $error("reply did not finish in time");
endmodule

/* File: modbus_rtu_slave_port_tb.sv */
// self-checking bench: master and slave ends joined over the rtu link
`timescale 1ns/1ns
module modbus_rtu_slave_port_tb import modbus_rtu_pkg::*; ;
	logic        sys_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        cmd_valid, cmd_write, spoil, bad, cmd_ready, rsp_valid, word_valid, wr_valid, wr_wide;
	logic [7:0]  cmd_id, rsp_code, slave_id;
	logic [15:0] cmd_addr, cmd_value, word, rd_addr, rd_data, rd_addr2, rd_data2, wr_addr;
	logic [31:0] wr_data;
	rsp_status_t rsp_status;
	logic [15:0] regs [256];
	logic [7:0]  tx_q [$];
	logic [7:0]  rx_q [$];
	logic [7:0]  rx2_q [$];
	logic [15:0] words_q [$];
	int          error_cnt = 0;
	int          compares = 0;
	int          cycles = 0;
	int          wr_cnt = 0;
	int          cyc;
	int          n;

	always #2 sys_clk_in = ~sys_clk_in;
	modbus_rtu_link_if lnk ();
	modbus_rtu_link_if lnk2 ();

	modbus_rtu_master_port #(.WAIT_LIMIT(32'd1000)) modbus_rtu_master_port_inst (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .link(lnk.master_port), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_write_in(cmd_write), .cmd_id_in(cmd_id), .cmd_addr_in(cmd_addr), .cmd_value_in(cmd_value),
		.cmd_spoil_crc_in(spoil), .cmd_bad_char_in(bad), .rsp_valid_out(rsp_valid), .rsp_status_out(rsp_status),
		.rsp_code_out(rsp_code), .word_valid_out(word_valid), .word_out(word));
	modbus_rtu_slave_port #(.RESP_LIMIT(32'd600)) modbus_rtu_slave_port_inst (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .link(lnk.slave_port), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
		.wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_wide_out(wr_wide),
		.slave_id_out(slave_id));
	// second slave meets a raw rule-breaking driver
	modbus_rtu_slave_port #(.RESP_LIMIT(32'd600)) modbus_rtu_slave_port_inst2 (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .link(lnk2.slave_port), .rd_addr_out(rd_addr2), .rd_data_in(rd_data2),
		.wr_valid_out(), .wr_addr_out(), .wr_data_out(), .wr_wide_out(), .slave_id_out());
	modbus_rtu_slave_port_assertions modbus_rtu_slave_port_assertions_inst (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .m2s_valid(lnk.m2s_valid), .m2s_data(lnk.m2s_data), .m2s_last(lnk.m2s_last),
		.m2s_err(lnk.m2s_err), .s2m_valid(lnk.s2m_valid), .s2m_ready(lnk.s2m_ready), .s2m_data(lnk.s2m_data),
		.s2m_last(lnk.s2m_last));

	assign rd_data = regs[rd_addr[7:0]];
	assign rd_data2 = regs[rd_addr2[7:0]];

	function automatic logic [15:0] exp_reg(input int i);
		return {8'(i) ^ 8'h5A, 8'(i)};
	endfunction

	// residue of a whole frame, crc low byte first, is zero
	function automatic logic [15:0] crc_of(input logic [7:0] q [$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic cmd(input logic wr, input logic [7:0] id, input logic [15:0] a, input logic [15:0] v,
			input logic [1:0] fault, input rsp_status_t st);
		tx_q.delete();
		rx_q.delete();
		words_q.delete();
		@(posedge sys_clk_in);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_id    <= id;
		cmd_addr  <= a;
		cmd_value <= v;
		spoil     <= fault[0];
		bad       <= fault[1];
		@(posedge sys_clk_in);
		cmd_valid <= 1'b0;
		for (cyc = 0; cyc < 2000; cyc++) begin
			#1;
			if (rsp_valid === 1'b1) break;
			@(posedge sys_clk_in);
		end
		check({rsp_valid, cmd_ready}, 2'b11);
		check(rsp_status, st);
		if (tx_q.size()) check(crc_of(tx_q) == 16'h0000, !fault[0]);
		if (rx_q.size() > 0) check(crc_of(rx_q), 16'h0000);
	endtask

	task automatic raw_req(input logic [7:0] fc, input logic [15:0] v, input logic [15:0] exp);
		logic [7:0]  f [$];
		logic [15:0] c;
		f = {8'h01, fc, 8'h00, 8'h05, v[15:8], v[7:0]};
		c = crc_of(f);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		rx2_q.delete();
		foreach (f[i]) begin
			@(posedge sys_clk_in);
			lnk2.m2s_valid <= 1'b1;
			lnk2.m2s_data  <= f[i];
			lnk2.m2s_last  <= (i == 7);
		end
		@(posedge sys_clk_in);
		lnk2.m2s_valid <= 1'b0;
		lnk2.m2s_last  <= 1'b0;
		lnk2.m2s_data  <= ~f[7];
		repeat (20) @(posedge sys_clk_in);
		#1;
		check(rx2_q.size(), 5);
		check({rx2_q[1], rx2_q[2]}, exp);
	endtask

	always @(posedge sys_clk_in) begin
		cycles++;
		if (lnk.m2s_valid) tx_q.push_back(lnk.m2s_data);
		if (lnk.s2m_valid && lnk.s2m_ready) rx_q.push_back(lnk.s2m_data);
		if (lnk2.s2m_valid) rx2_q.push_back(lnk2.s2m_data);
		if (word_valid) words_q.push_back(word);
		if (wr_valid) begin
			wr_cnt++;
			if (wr_wide) begin
				regs[wr_addr[7:0]] <= wr_data[31:16];
				regs[wr_addr[7:0] + 8'h01] <= wr_data[15:0];
			end else begin
				regs[wr_addr[7:0]] <= wr_data[15:0];
			end
		end
		// hung handshake ends the run
		if (cycles == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	initial begin
		{cmd_valid, cmd_write, spoil, bad, cmd_id, cmd_addr, cmd_value} = '0;
		{lnk2.m2s_valid, lnk2.m2s_data, lnk2.m2s_last, lnk2.m2s_err} = '0;
		lnk2.s2m_ready = 1'b1;
		for (int i = 0; i < 256; i++) regs[i] = exp_reg(i);
		repeat (16) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
		check(slave_id, 8'h01);
		cmd(1'b0, 8'h01, 16'h0005, 16'h0001, 2'b00, ST_OK);
		check(rx_q.size(), 7);
		check(rx_q[2], 8'h02);
		check({tx_q[1], tx_q[2], tx_q[3]}, 24'h030005);
		check(words_q[0], exp_reg(5));
		cmd(1'b0, 8'h01, 16'h0010, 16'h007D, 2'b00, ST_OK);
		check(rx_q.size(), 255);
		check(words_q.size(), 125);
		check(cyc < 600, 1'b1);
		foreach (words_q[i]) check(words_q[i], exp_reg(16 + i));
		cmd(1'b1, 8'h01, 16'h0007, 16'h1234, 2'b00, ST_OK);
		check({wr_cnt[3:0], wr_wide, wr_addr, wr_data}, {4'h1, 1'b0, 16'h0007, 32'h00001234});
		check({rx_q.size(), rx_q[4], rx_q[5]}, {32'd8, 16'h1234});
		cmd(1'b0, 8'h01, 16'h0007, 16'h0001, 2'b00, ST_OK);
		check(words_q[0], 16'h1234);
		cmd(1'b0, 8'h01, 16'h0000, 16'h0001, 2'b00, ST_OK);
		check(words_q[0], exp_reg(0));
		regs[1] <= 16'hBEEF;
		cmd(1'b0, 8'h01, 16'h0001, 16'h0001, 2'b00, ST_OK);
		check(words_q[0], exp_reg(1));
		n = wr_cnt;
		cmd(1'b1, 8'h01, 16'h0000, 16'h1111, 2'b00, ST_OK);
		check(wr_cnt, n);
		cmd(1'b1, 8'h01, 16'h0001, 16'h2222, 2'b00, ST_OK);
		check({wr_cnt - n, wr_wide, wr_addr, wr_data}, {32'd1, 1'b1, 16'h0000, 32'h11112222});
		cmd(1'b0, 8'h01, 16'h00FF, 16'h0002, 2'b00, ST_EXC);
		check({rx_q.size(), rx_q[1], rsp_code}, {32'd5, 16'h8302});
		cmd(1'b0, 8'h01, 16'h00FE, 16'h0002, 2'b00, ST_OK);
		check(words_q.size(), 2);
		cmd(1'b1, 8'h01, 16'h0100, 16'h0005, 2'b00, ST_EXC);
		check({rx_q.size(), rx_q[1], rsp_code}, {32'd5, 16'h8602});
		cmd(1'b0, 8'h02, 16'h0005, 16'h0001, 2'b00, ST_TIMEOUT);
		check(rx_q.size(), 0);
		check(cyc >= 990, 1'b1);
		for (int k = 0; k < 2; k++) begin
			cmd(1'b0, 8'h01, 16'h0005, 16'h0001, 2'(k + 1), ST_TIMEOUT);
			check(rx_q.size(), 0);
		end
		cmd(1'b1, 8'h01, ID_REG, 16'h0005, 2'b00, ST_OK);
		check(slave_id, 8'h05);
		cmd(1'b0, 8'h05, ID_REG, 16'h0001, 2'b00, ST_OK);
		check(words_q[0], 16'h0005);
		cmd(1'b0, 8'h01, 16'h0005, 16'h0001, 2'b00, ST_TIMEOUT);
		check(rx_q.size(), 0);
		cmd(1'b0, 8'h05, 16'h0005, 16'h0000, 2'b00, ST_BADCMD);
		check(tx_q.size(), 0);
		raw_req(8'h03, 16'h0000, 16'h8303);
		raw_req(8'h03, 16'h007E, 16'h8303);
		raw_req(8'h10, 16'h0001, 16'h9001);
		final_report();
	end
endmodule
